/* File: pkg/lpa_params.svh */
// Purpose: constants of the ladder link node and its controller
// Assumes: 100 MHz ref_clk, open-drain data line, host-made link clock
// Notes: timing counts derive from their printed figures
//
// Notes on behaviour
// - assignment broadcast gives each node unique address
// - first node adopts start, passes start plus one
// - five-bit address, wraps past top to zero
// - forward single write only when target is higher
// - upper clock stuck over 28ms aborts like STOP
// - host may idle over 28ms to reset chain
// - after pack change rerun assign, poll, top-set
// - check byte bit7 is alarm, bits 6..1 zero
// - check byte bit0 flags bad or flagged upstream code
// - commit writes only after correct lower-port code
// - ack after code byte tells write validity
// - code alert raises alarm only when mask set
// - crc-8 polynomial is x^8+x^2+x+1, 0x07
// - crc covers address, command, data, check bytes
// - crc starts at zero, bits msb first
// - xor byte in, eight shifts, conditional polynomial xor
// - each byte continues from previous working crc
// - host computes code over its transmitted bytes
// - host checks received code on broadcast reads
// - host may confirm writes with a broadcast read
// - bad upper code sets chain flag and alert
// - intermediate node merges upstream check byte, recomputes code
`ifndef LPA_PARAMS_SVH
`define LPA_PARAMS_SVH
`define LPA_CRC_POLY 8'h07
`define LPA_ADDR_BCAST_WR 8'h40
`define LPA_ADDR_BCAST_RD 8'h41
`define LPA_ADDR_SINGLE 2'h2
`define LPA_CMD_ASSIGN 8'hf0
`define LPA_CMD_POLL 8'hf1
`define LPA_CMD_TOPSET 8'hf2
`define LPA_REG_CFG 8'h08
`define LPA_CFG_MASK_BIT 0
`define LPA_CLK_HZ 100000000
`define LPA_TIMEOUT_MS 28
`define LPA_TIMEOUT_CYC (`LPA_TIMEOUT_MS * (`LPA_CLK_HZ / 1000))
`define LPA_LINK_NS 160
`define LPA_CLK_NS 10
`define LPA_QTR_CYC (`LPA_LINK_NS / (4 * `LPA_CLK_NS))
`define LPA_HREG_CTRL 4'h0
`define LPA_HREG_CMD 4'h1
`define LPA_HREG_DATA 4'h2
`define LPA_HREG_STAT 4'h3
`define LPA_HREG_RX 4'h4
`endif

/* File: pkg/lpa_pkg.sv */
package lpa_pkg;
  typedef enum logic [1:0] {LPA_K_NONE = 2'b00, LPA_K_BCAST = 2'b01,
    LPA_K_SINGLE = 2'b10, LPA_K_READ = 2'b11} lpa_kind_e;
  typedef enum logic [1:0] {LPA_DM_IDLE = 2'b00, LPA_DM_RX = 2'b01,
    LPA_DM_TX = 2'b10} lpa_dmode_e;
  typedef enum logic [2:0] {LPA_H_IDLE = 3'b000, LPA_H_GAP = 3'b001,
    LPA_H_START = 3'b010, LPA_H_BIT = 3'b011, LPA_H_RSTART = 3'b100,
    LPA_H_STOP = 3'b101} lpa_hst_e;
endpackage : lpa_pkg

/* File: pkg/lpa_link_if.sv */
// Purpose: lower-port link between controller and first ladder node
// Assumes: link clock pushed by the controller, data line open drain
// Notes: a driver pulls low when its enable is high and its value low
`timescale 1ns/100ps
`default_nettype none
interface lpa_link_if;
  logic scl_o;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  assign scl = scl_o;
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output scl_o, output h_sda_o, output h_sda_oe, input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : lpa_link_if
`default_nettype wire

/* File: core/lpa_crc8.sv */
// Purpose: one byte step of the link crc-8
// Assumes: caller holds the running value between bytes
// Notes: purely combinational, eight shifts unrolled by a loop
`timescale 1ns/100ps
`default_nettype none
`include "lpa_params.svh"
module lpa_crc8
  import lpa_pkg::*;
(
  // running value and new byte
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  // value after the byte
  output logic [7:0] crc_out
);
  logic [7:0] rem;
  always_comb
  begin
    rem = crc_in ^ data_in;
    for (int i = 0; i < 8; i++)
    begin
      rem = rem[7] ? ({rem[6:0], 1'b0} ^ `LPA_CRC_POLY) : {rem[6:0], 1'b0};
    end
    crc_out = rem;
  end
endmodule : lpa_crc8
`default_nettype wire

/* File: core/lpa_ladder_dev.sv */
// Purpose: ladder node lower port: addressing, crc check, check byte
// Assumes: link signals and pins asynchronous to ref_clk
// Notes: register file sits outside, fed by the commit strobe
`timescale 1ns/100ps
`default_nettype none
`include "lpa_params.svh"
module lpa_ladder_dev
  import lpa_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `LPA_TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // lower port
  lpa_link_if.dev link,
  // upper side of the chain
  input wire logic upper_port_clock_in,
  input wire logic [7:0] up_check_byte,
  input wire logic up_pec_bad,
  output logic [4:0] up_next_addr,
  output logic up_fwd,
  // alarm and register file
  input wire logic lower_alarm_pin,
  input wire logic alert_clr,
  input wire logic [15:0] rd_data,
  output logic [4:0] own_addr,
  output logic wr_stb,
  output logic [7:0] wr_reg,
  output logic [15:0] wr_data,
  output logic [7:0] check_byte,
  output logic crc_alert_flag,
  output logic alarm_out
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] raw, q0, q1, q2, filt;
  assign raw = {lower_alarm_pin, upper_port_clock_in, link.sda, link.scl};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          q0[gi] <= 1'b1;
          q1[gi] <= 1'b1;
          q2[gi] <= 1'b1;
          filt[gi] <= 1'b1;
        end
        else
        begin
          q0[gi] <= raw[gi];
          q1[gi] <= q0[gi];
          q2[gi] <= q1[gi];
          if (q1[gi] == q2[gi])
            filt[gi] <= q2[gi];
        end
      end
    end
  endgenerate
  wire scl_f = filt[0];
  wire sda_f = filt[1];
  wire upc_f = filt[2];
  wire alm_f = filt[3];
  logic scl_d, sda_d, upc_d;
  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_ev = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_ev = scl_f & scl_d & ~sda_d & sda_f;

  // ----------------------------------------------------------------
  // stuck upper clock timeout
  // ----------------------------------------------------------------
  logic [31:0] to_cnt;
  wire to_ev = (upc_f == upc_d) && (to_cnt == TIMEOUT_CYC - 1);
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      upc_d <= 1'b1;
      to_cnt <= 32'h0;
    end
    else
    begin
      scl_d <= scl_f;
      sda_d <= sda_f;
      upc_d <= upc_f;
      if (upc_f != upc_d)
        to_cnt <= 32'h0;
      else if (to_cnt != TIMEOUT_CYC)
        to_cnt <= to_cnt + 32'h1;
    end
  end
  wire abort = stop_ev | to_ev;

  // ----------------------------------------------------------------
  // byte engine state
  // ----------------------------------------------------------------
  lpa_dmode_e mode;
  lpa_kind_e kind;
  logic [2:0] byte_idx;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, crc_run, cmd, d0, d1, tx_cur, cfg;
  logic [4:0] target;
  logic [1:0] tidx;
  logic ack_en, rd_pend, tx_go, sda_oe;
  logic [7:0] crc_nxt, tx_next;
  wire [7:0] b_full = {shreg[6:0], sda_f};
  wire is_single = b_full[7:6] == `LPA_ADDR_SINGLE;
  // address bits arrive lsb first after the two fixed bits
  wire [4:0] tgt_w = {b_full[1], b_full[2], b_full[3], b_full[4], b_full[5]};
  wire pec_ok = b_full == crc_run;
  wire exec_me = (kind == LPA_K_BCAST) || (target == own_addr);
  wire byte_done = scl_rise && (bit_cnt == 4'h7) && (mode != LPA_DM_IDLE);
  wire rx_done = byte_done && (mode == LPA_DM_RX);
  wire pec_byte = rx_done && (byte_idx == 3'h4) && (kind != LPA_K_NONE);
  wire pec_fail = pec_byte && !pec_ok;
  wire [15:0] rd_val = (cmd == `LPA_CMD_POLL) ? {11'h0, own_addr} : rd_data;
  wire [7:0] chk_w = {alm_f | up_check_byte[7], 6'h0, up_check_byte[0] | up_pec_bad};
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = sda_oe;
  lpa_crc8 u_crc (
    .crc_in(crc_run),
    .data_in((mode == LPA_DM_TX) ? tx_cur : b_full),
    .crc_out(crc_nxt)
  );
  always_comb
  begin
    case (tidx)
      2'h0: tx_next = rd_val[7:0];
      2'h1: tx_next = rd_val[15:8];
      2'h2: tx_next = chk_w;
      default: tx_next = crc_run;
    endcase
  end

  // ----------------------------------------------------------------
  // link protocol
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= LPA_DM_IDLE;
      kind <= LPA_K_NONE;
      byte_idx <= 3'h0;
      bit_cnt <= 4'h0;
      shreg <= 8'h0;
      crc_run <= 8'h0;
      cmd <= 8'h0;
      d0 <= 8'h0;
      d1 <= 8'h0;
      tx_cur <= 8'h0;
      cfg <= 8'h0;
      target <= 5'h0;
      tidx <= 2'h0;
      ack_en <= 1'b0;
      rd_pend <= 1'b0;
      tx_go <= 1'b0;
      sda_oe <= 1'b0;
      own_addr <= 5'h0;
      up_next_addr <= 5'h0;
      up_fwd <= 1'b0;
      wr_stb <= 1'b0;
      wr_reg <= 8'h0;
      wr_data <= 16'h0;
    end
    else
    begin
      wr_stb <= 1'b0;
      up_fwd <= 1'b0;
      if (start_ev)
      begin
        // a read keeps its running crc across the repeated start
        rd_pend <= (mode == LPA_DM_RX) && (kind == LPA_K_BCAST) && (byte_idx == 3'h2);
        if (!((mode == LPA_DM_RX) && (kind == LPA_K_BCAST) && (byte_idx == 3'h2)))
          crc_run <= 8'h0;
        mode <= LPA_DM_RX;
        byte_idx <= 3'h0;
        bit_cnt <= 4'h0;
        tidx <= 2'h0;
        tx_go <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (abort)
      begin
        mode <= LPA_DM_IDLE;
        rd_pend <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (mode != LPA_DM_IDLE)
      begin
        if (scl_rise && bit_cnt == 4'h8)
        begin
          bit_cnt <= 4'h0;
          if ((mode == LPA_DM_TX) && sda_f)
            mode <= LPA_DM_IDLE;
          else if ((mode == LPA_DM_TX) || tx_go)
          begin
            mode <= LPA_DM_TX;
            tx_cur <= tx_next;
            tidx <= tidx + 2'h1;
          end
          else if (!ack_en)
            mode <= LPA_DM_IDLE;
        end
        else if (scl_rise)
        begin
          shreg <= b_full;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h7)
            crc_run <= crc_nxt;
        end
        if (scl_fall)
        begin
          if (bit_cnt == 4'h8)
            sda_oe <= (mode == LPA_DM_RX) && ack_en;
          else
            sda_oe <= (mode == LPA_DM_TX) && !tx_cur[~bit_cnt[2:0]];
        end
        if (rx_done)
        begin
          if (byte_idx != 3'h7)
            byte_idx <= byte_idx + 3'h1;
          case (byte_idx)
            3'h0:
            begin
              rd_pend <= 1'b0;
              target <= tgt_w;
              if (rd_pend && b_full == `LPA_ADDR_BCAST_RD)
              begin
                tx_go <= 1'b1;
                ack_en <= 1'b1;
              end
              else if (b_full == `LPA_ADDR_BCAST_WR)
              begin
                kind <= LPA_K_BCAST;
                ack_en <= 1'b1;
              end
              else if (is_single)
              begin
                kind <= LPA_K_SINGLE;
                ack_en <= tgt_w >= own_addr;
              end
              else
              begin
                kind <= LPA_K_NONE;
                ack_en <= 1'b0;
              end
            end
            3'h1: cmd <= b_full;
            3'h2: d0 <= b_full;
            3'h3: d1 <= b_full;
            3'h4:
            begin
              ack_en <= pec_ok && (kind != LPA_K_NONE);
              if (kind == LPA_K_SINGLE && target > own_addr)
                up_fwd <= 1'b1;
              if (pec_ok && exec_me && kind != LPA_K_NONE)
              begin
                wr_stb <= 1'b1;
                wr_reg <= cmd;
                wr_data <= {d1, d0};
                if (cmd == `LPA_REG_CFG)
                  cfg <= d0;
                if (cmd == `LPA_CMD_ASSIGN)
                begin
                  own_addr <= d0[4:0];
                  up_next_addr <= d0[4:0] + 5'h1;
                end
              end
            end
            default: ack_en <= 1'b0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // alert, alarm and check byte
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crc_alert_flag <= 1'b0;
      alarm_out <= 1'b0;
      check_byte <= 8'h0;
    end
    else
    begin
      // a new failure wins over a clear in the same cycle
      crc_alert_flag <= pec_fail | up_pec_bad | (crc_alert_flag & ~alert_clr);
      alarm_out <= crc_alert_flag & cfg[`LPA_CFG_MASK_BIT];
      check_byte <= chk_w;
    end
  end
endmodule : lpa_ladder_dev
`default_nettype wire

/* File: core/lpa_ladder_host.sv */
// Purpose: ladder controller driving one lower-port link
// Assumes: software sets kind, command, target and data before go
// Notes: link clock made here from ref_clk, four phases per bit
`timescale 1ns/100ps
`default_nettype none
`include "lpa_params.svh"
module lpa_ladder_host
  import lpa_pkg::*;
#(
  parameter int unsigned GAP_CYC = `LPA_TIMEOUT_CYC + 1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // link
  lpa_link_if.host link
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lpa_kind_e kind;
  lpa_hst_e st;
  logic wake, busy, ack_ok, pec_ok, scl_q, sda_oe, sda_s;
  logic [7:0] cmd, crc, sh, rx_chk, rx_pec;
  logic [4:0] target;
  logic [15:0] data, rx_dat;
  logic [1:0] qcnt, ph;
  logic [3:0] bit_n;
  logic [2:0] idx, sda_q;
  logic [31:0] gap;
  logic [7:0] crc_nxt, hb;
  wire rd_kind = kind == LPA_K_READ;
  wire rx = rd_kind && idx >= 3'h3;
  wire tick = qcnt == 2'(`LPA_QTR_CYC - 1);
  wire go = reg_wr && reg_addr == `LPA_HREG_CTRL && reg_wdata[3] && !busy;
  wire [7:0] addr0 = (kind == LPA_K_SINGLE) ? {`LPA_ADDR_SINGLE, target[0], target[1],
    target[2], target[3], target[4], 1'b0} : `LPA_ADDR_BCAST_WR;
  wire pec_idx = rd_kind ? (idx == 3'h6) : (idx == 3'h4);
  wire [31:0] rd_mux = (reg_addr == `LPA_HREG_CTRL) ? {29'h0, wake, kind} :
    (reg_addr == `LPA_HREG_CMD) ? {19'h0, target, cmd} :
    (reg_addr == `LPA_HREG_DATA) ? {16'h0, data} :
    (reg_addr == `LPA_HREG_STAT) ? {29'h0, pec_ok, ack_ok, busy} :
    (reg_addr == `LPA_HREG_RX) ? {rx_pec, rx_chk, rx_dat} : 32'h0;
  always_comb
  begin
    case (idx)
      3'h0: hb = addr0;
      3'h1: hb = cmd;
      3'h2: hb = rd_kind ? `LPA_ADDR_BCAST_RD : data[7:0];
      3'h3: hb = data[15:8];
      default: hb = crc;
    endcase
  end
  assign link.scl_o = scl_q;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe = sda_oe;
  lpa_crc8 u_crc (
    .crc_in(crc),
    .data_in(rx ? sh : hb),
    .crc_out(crc_nxt)
  );
  // data line comes from another chip: three flops, taken once two agree
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_q <= 3'h7;
      sda_s <= 1'b1;
    end
    else
    begin
      sda_q <= {sda_q[1:0], link.sda};
      if (sda_q[1] == sda_q[2])
        sda_s <= sda_q[2];
    end
  end

  // ----------------------------------------------------------------
  // software port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 32'h0;
      kind <= LPA_K_BCAST;
      wake <= 1'b0;
      cmd <= 8'h0;
      target <= 5'h0;
      data <= 16'h0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      if (reg_wr && !busy)
      begin
        if (reg_addr == `LPA_HREG_CTRL)
        begin
          kind <= lpa_kind_e'(reg_wdata[1:0]);
          wake <= reg_wdata[2];
        end
        if (reg_addr == `LPA_HREG_CMD)
        begin
          cmd <= reg_wdata[7:0];
          target <= reg_wdata[12:8];
        end
        if (reg_addr == `LPA_HREG_DATA)
          data <= reg_wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= LPA_H_IDLE;
      busy <= 1'b0;
      ack_ok <= 1'b0;
      pec_ok <= 1'b0;
      scl_q <= 1'b1;
      sda_oe <= 1'b0;
      crc <= 8'h0;
      sh <= 8'h0;
      rx_dat <= 16'h0;
      rx_chk <= 8'h0;
      rx_pec <= 8'h0;
      qcnt <= 2'h0;
      ph <= 2'h0;
      bit_n <= 4'h0;
      idx <= 3'h0;
      gap <= 32'h0;
    end
    else
    begin
      qcnt <= tick ? 2'h0 : qcnt + 2'h1;
      if (go)
      begin
        busy <= 1'b1;
        ack_ok <= 1'b1;
        pec_ok <= 1'b0;
        crc <= 8'h0;
        idx <= 3'h0;
        gap <= 32'h0;
        ph <= 2'h0;
        st <= reg_wdata[2] ? LPA_H_GAP : LPA_H_START;
      end
      else if (st == LPA_H_GAP)
      begin
        gap <= gap + 32'h1;
        if (gap == GAP_CYC)
          st <= LPA_H_START;
      end
      else if (tick && st != LPA_H_IDLE)
      begin
        ph <= ph + 2'h1;
        case (st)
          LPA_H_START:
          begin
            if (ph == 2'h1)
              sda_oe <= 1'b1;
            if (ph == 2'h2)
              scl_q <= 1'b0;
            if (ph == 2'h3)
            begin
              st <= LPA_H_BIT;
              bit_n <= 4'h0;
            end
          end
          LPA_H_RSTART:
          begin
            if (ph == 2'h0)
              sda_oe <= 1'b0;
            if (ph == 2'h1)
              scl_q <= 1'b1;
            if (ph == 2'h2)
              sda_oe <= 1'b1;
            if (ph == 2'h3)
            begin
              scl_q <= 1'b0;
              st <= LPA_H_BIT;
              bit_n <= 4'h0;
            end
          end
          LPA_H_STOP:
          begin
            if (ph == 2'h0)
              sda_oe <= 1'b1;
            if (ph == 2'h1)
              scl_q <= 1'b1;
            if (ph == 2'h2)
              sda_oe <= 1'b0;
            if (ph == 2'h3)
            begin
              st <= LPA_H_IDLE;
              busy <= 1'b0;
              pec_ok <= rd_kind ? (crc == rx_pec) : ack_ok;
            end
          end
          default:
          begin
            if (ph == 2'h0)
              sda_oe <= (bit_n == 4'h8) ? (rx && idx != 3'h6) : (!rx && !hb[~bit_n[2:0]]);
            if (ph == 2'h1)
              scl_q <= 1'b1;
            if (ph == 2'h2 && bit_n != 4'h8)
              sh <= {sh[6:0], sda_s};
            if (ph == 2'h2 && bit_n == 4'h8 && !rx && sda_s)
              ack_ok <= 1'b0;
            if (ph == 2'h3)
            begin
              scl_q <= 1'b0;
              bit_n <= bit_n + 4'h1;
              if (bit_n == 4'h7 && !pec_idx)
                crc <= crc_nxt;
              if (bit_n == 4'h7 && idx == 3'h3 && rx)
                rx_dat[7:0] <= sh;
              if (bit_n == 4'h7 && idx == 3'h4 && rx)
                rx_dat[15:8] <= sh;
              if (bit_n == 4'h7 && idx == 3'h5 && rx)
                rx_chk <= sh;
              if (bit_n == 4'h7 && idx == 3'h6)
                rx_pec <= sh;
              if (bit_n == 4'h8)
              begin
                bit_n <= 4'h0;
                idx <= idx + 3'h1;
                if (rd_kind && idx == 3'h1)
                  st <= LPA_H_RSTART;
                else if (pec_idx)
                  st <= LPA_H_STOP;
              end
            end
          end
        endcase
      end
    end
  end
endmodule : lpa_ladder_host
`default_nettype wire

/* File: tb/lpa_link_checker.sv */
// Purpose: wire-level checks on the link between controller and node
// Assumes: one ref_clk domain, link signals sampled as plain inputs
// Notes: clock phase widths, the node's data enable and data moves under a high clock are judged
`timescale 1ns/100ps
`default_nettype none
module lpa_link_checker
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link signals
  input wire logic scl_o,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // -----------------------------
  // properties
  // -----------------------------
  property p_dev_edge_low; $changed(d_sda_oe) |-> !scl; endproperty
  property p_ack_width; $rose(d_sda_oe) |-> d_sda_oe [*4]; endproperty
  property p_scl_hi_min; $rose(scl) |-> scl [*4]; endproperty
  property p_scl_lo_min; $fell(scl) |-> !scl [*4]; endproperty
  property p_scl_lo_max; $fell(scl) |-> ##[1:32] scl; endproperty
  property p_start_quiet; ($fell(sda) && scl) |-> !d_sda_oe [*8]; endproperty
  property p_stop_quiet; ($rose(sda) && scl) |-> !d_sda_oe [*8]; endproperty
  // while the clock is high only the controller may move the data line
  property p_high_stable; (scl && $past(scl) && $changed(sda)) |-> $changed(h_sda_oe);
  endproperty
  a_dev_edge_low: assert property (p_dev_edge_low)
    else $error("node data moved while clock high");
  a_ack_width: assert property (p_ack_width)
    else $error("node acknowledge too short");
  a_scl_hi_min: assert property (p_scl_hi_min)
    else $error("clock high phase too short");
  a_scl_lo_min: assert property (p_scl_lo_min)
    else $error("clock low phase too short");
  a_scl_lo_max: assert property (p_scl_lo_max)
    else $error("clock held low too long");
  a_start_quiet: assert property (p_start_quiet)
    else $error("node drove data right after start");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("node drove data after stop");
  a_high_stable: assert property (p_high_stable)
    else $error("data moved under high clock without controller");
  c_ack: cover property ($rose(d_sda_oe));
  c_start: cover property ($fell(sda) && scl);
  c_node_bit: cover property (d_sda_oe && scl);
endmodule : lpa_link_checker
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: controller and ladder node joined by one link
// Assumes: short timeout and wake gap, upper clock toggled by bench
// Notes: expected codes come from a bench crc model
`timescale 1ns/100ps
`default_nettype none
`include "lpa_params.svh"
module testbench
  import lpa_pkg::*;
;
  logic ref_clk, reset_n, reg_wr, reg_rd, uclk, uclk_en, alarm_pin;
  logic up_fwd, wr_stb, alert, alarm_out;
  logic [1:0] pls;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, st;
  logic [7:0] up_chk, check_byte, wr_reg, acc;
  logic [15:0] rd_data, wr_data;
  logic [4:0] own_addr, next_addr;
  logic [7:0] ex [4] = '{8'h40, 8'h09, 8'hff, 8'h03};
  logic [7:0] cu [3] = '{8'h01, 8'h7e, 8'h00};
  logic [7:0] ce [3] = '{8'h81, 8'h00, 8'h01};
  logic [7:0] bs [6];
  int mismatches, n_checks, fwd_n, wr_n, w0, f0;
  lpa_link_if lpa_link_if_i();
  lpa_ladder_host #(.GAP_CYC(50)) lpa_ladder_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link(lpa_link_if_i));
  lpa_ladder_dev #(.TIMEOUT_CYC(200)) lpa_ladder_dev_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(lpa_link_if_i), .upper_port_clock_in(uclk), .up_check_byte(up_chk),
    .up_pec_bad(pls[0]), .up_next_addr(next_addr), .up_fwd(up_fwd),
    .lower_alarm_pin(alarm_pin), .alert_clr(pls[1]), .rd_data(rd_data), .own_addr(own_addr),
    .wr_stb(wr_stb), .wr_reg(wr_reg), .wr_data(wr_data), .check_byte(check_byte),
    .crc_alert_flag(alert), .alarm_out(alarm_out));
  lpa_link_checker lpa_link_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl_o(lpa_link_if_i.scl_o), .h_sda_o(lpa_link_if_i.h_sda_o),
    .h_sda_oe(lpa_link_if_i.h_sda_oe), .d_sda_o(lpa_link_if_i.d_sda_o),
    .d_sda_oe(lpa_link_if_i.d_sda_oe), .scl(lpa_link_if_i.scl), .sda(lpa_link_if_i.sda));
  // -----------------------------
  // helpers
  // -----------------------------
  function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ `LPA_CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction : crc_b
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
  endtask : rd
  // ctl is wake and kind; leaves final status in st
  task automatic xfer(input logic [2:0] ctl, input logic [7:0] cmd, input logic [4:0] tgt,
    input logic [15:0] d);
    wr(`LPA_HREG_DATA, {16'h0, d});
    wr(`LPA_HREG_CMD, {19'h0, tgt, cmd});
    wr(`LPA_HREG_CTRL, {28'h0, 1'b1, ctl});
    rv = 32'h1;
    for (int i = 0; i < 4000 && rv[0] !== 1'b0; i++) rd(`LPA_HREG_STAT);
    st = rv;
    chk("busy", {31'h0, st[0]}, 32'h0);
  endtask : xfer
  task automatic pulse(input int k);
    @(posedge ref_clk);
    pls[k] <= 1'b1;
    @(posedge ref_clk);
    pls[k] <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : pulse
  task wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // -----------------------------
  // stimulus
  // -----------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always
  begin
    #80;
    if (uclk_en) uclk = ~uclk;
  end
  always @(posedge ref_clk)
  begin
    if (up_fwd === 1'b1) fwd_n++;
    if (wr_stb === 1'b1) wr_n++;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    wrap_up;
  end
  initial
  begin
    {reset_n, reg_wr, reg_rd, alarm_pin, pls, reg_addr, reg_wdata} = '0;
    {up_chk, rd_data} = '0;
    uclk = 1'b1;
    uclk_en = 1'b1;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    acc = 8'h00;
    foreach (ex[i]) acc = crc_b(acc, ex[i]);
    chk("crc8", acc, 8'h7f);
    xfer(3'b101, `LPA_CMD_ASSIGN, 5'h0, 16'h001f);
    chk("own", own_addr, 5'h1f);
    chk("next", next_addr, 5'h00);
    xfer(3'b001, `LPA_CMD_ASSIGN, 5'h0, 16'h0005);
    chk("own", own_addr, 5'h05);
    chk("next", next_addr, 5'h06);
    xfer(3'b011, `LPA_CMD_POLL, 5'h0, 16'h0);
    rd(`LPA_HREG_RX);
    chk("poll", rv[4:0], 5'h05);
    xfer(3'b001, `LPA_CMD_TOPSET, 5'h0, 16'h0);
    xfer(3'b001, ex[1], 5'h0, {ex[3], ex[2]});
    chk("crcwr", {st[2], wr_reg, wr_data}, {1'b1, ex[1], ex[3], ex[2]});
    for (int t = 3; t <= 7; t += 2)
    begin
      w0 = wr_n;
      f0 = fwd_n;
      xfer(3'b010, 8'h0a, t[4:0], 16'h1234 + t[15:0]);
      chk("commit", wr_n - w0, t == 5);
      chk("fwd", fwd_n - f0, t == 7);
      chk("ack", st[1], t >= 5);
    end
    chk("wreg", {wr_reg, wr_data}, {8'h0a, 16'h1239});
    // a frozen upper clock must abort the write in flight
    uclk_en <= 1'b0;
    w0 = wr_n;
    xfer(3'b010, 8'h0a, 5'h05, 16'h0);
    chk("abort", wr_n - w0, 0);
    chk("abortack", st[1], 1'b0);
    uclk_en <= 1'b1;
    for (int m = 1; m >= 0; m--)
    begin
      xfer(3'b001, `LPA_REG_CFG, 5'h0, m[15:0]);
      pulse(0);
      chk("alert", alert, 1'b1);
      chk("alarm", alarm_out, m[0]);
      pulse(1);
      chk("clr", {alert, alarm_out}, 2'b00);
    end
    for (int k = 0; k < 3; k++)
    begin
      alarm_pin <= (k == 0);
      up_chk <= cu[k];
      pls[0] <= (k == 2);
      rd_data <= 16'h1234 + k[15:0];
      xfer(3'b011, 8'h09, 5'h0, 16'h0);
      chk("pecok", st[2], 1'b1);
      rd(`LPA_HREG_RX);
      bs = '{8'h40, 8'h09, 8'h41, rd_data[7:0], rd_data[15:8], ce[k]};
      acc = 8'h00;
      foreach (bs[j]) acc = crc_b(acc, bs[j]);
      chk("data", rv[15:0], rd_data);
      chk("check", rv[23:16], ce[k]);
      chk("chkport", check_byte, ce[k]);
      chk("code", rv[31:24], acc);
    end
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
